//--- swa_pkg.sv
package swa_pkg;
   // Register map
   localparam logic [7:0] ADDR_CTRL     = 8'hE8;
   localparam logic [7:0] ADDR_LOW      = 8'h98;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] LOW_RESET     = 8'h00;
   // Control and low register field positions
   localparam int CTRL_RESULT_BIT = 7;
   localparam int CTRL_CH_HI_BIT  = 6;
   localparam int CTRL_CH_LO_BIT  = 5;
   localparam int CTRL_STROBE_BIT = 4;
   localparam int CTRL_DAC_MSB    = 3;
   localparam int LOW_DAC_MSB     = 3;
   // Channel codes
   localparam logic [1:0] CH_SEL_IN3 = 2'h0;
   localparam logic [1:0] CH_SEL_IN0 = 2'h1;
   localparam logic [1:0] CH_SEL_IN1 = 2'h2;
   localparam logic [1:0] CH_SEL_IN2 = 2'h3;
   // Timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int INSTR_CYCLE_NS = 1000;
   localparam int INSTR_CLKS_CALC = (INSTR_CYCLE_NS / CLK_PERIOD_NS) < 1 ?
                                    1 : (INSTR_CYCLE_NS / CLK_PERIOD_NS);
   localparam int SYNC_STAGES = 2;
   typedef enum logic {SWA_IDLE, SWA_CMP} swa_state_t;
endpackage

//--- swa_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pin-side levels
module swa_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stageOne;
   logic [WIDTH-1:0] next_stageOne;
   logic [WIDTH-1:0] next_syncOut;

   // Next values of both stages
   always_comb begin
      next_stageOne = asyncIn;
      next_syncOut  = stageOne;
   end

   // Registered stages
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stageOne <= '0;
         syncOut  <= '0;
      end else begin
         stageOne <= next_stageOne;
         syncOut  <= next_syncOut;
      end
   end
endmodule
`default_nettype wire

//--- swa_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// Input multiplexer and registered comparator
module swa_cmp
   import swa_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [1:0]       channelSel,
   input  wire logic [WIDTH-1:0] levelZero,
   input  wire logic [WIDTH-1:0] levelOne,
   input  wire logic [WIDTH-1:0] levelTwo,
   input  wire logic [WIDTH-1:0] levelThree,
   input  wire logic [WIDTH-1:0] dacLevel,
   output logic                  cmpHigh
);
   logic [WIDTH-1:0] selLevel;
   logic             next_cmpHigh;

   // Channel decode and compare
   always_comb begin
      // R1 channel decode
      case (channelSel)
         CH_SEL_IN3: selLevel = levelThree;
         CH_SEL_IN0: selLevel = levelZero;
         CH_SEL_IN1: selLevel = levelOne;
         CH_SEL_IN2: selLevel = levelTwo;
         default:    selLevel = levelThree;
      endcase
      // R10 input above reference
      next_cmpHigh = (selLevel > dacLevel);
   end

   // Registered comparator output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmpHigh <= 1'b0;
      end else begin
         cmpHigh <= next_cmpHigh;
      end
   end

   AST_MUX_PICK: assert property (@(posedge clk_sys) disable iff (rst) // R1
      (channelSel == CH_SEL_IN3) |=> (cmpHigh == ($past(levelThree) >
                                                  $past(dacLevel))))
      else $error("channel 00 does not compare input three");
endmodule
`default_nettype wire

//--- swa_top.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Two-bit channel field picks input three, zero, one or two in order.
// R2 - Port 3 lines 0 to 3 double as the four analogue inputs.
// R3 - Reference DAC: upper four bits from control, lower four from low.
// R4 - Comparator output readable as result bit of control register.
// R5 - Result valid within one instruction cycle after strobe set.
// R6 - Software writes upper DAC bits one instruction cycle before strobe.
// R7 - Only mux, DAC and comparator; software sequences the conversions.
// R8 - Control register at E8, reset 00, result/channel/strobe/DAC fields.
// R9 - Low register at 98, reset 00, low DAC nibble, upper bits zero.
// R10 - Result is one when selected input exceeds the DAC reference.
module swa_top
   import swa_pkg::*;
#(
   parameter int DAC_WIDTH  = 8,
   parameter int INSTR_CLKS = INSTR_CLKS_CALC
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic [7:0]           busAddr,
   input  wire logic [7:0]           busWrData,
   input  wire logic                 busWr,
   input  wire logic                 busRd,
   output logic      [7:0]           busRdData,
   input  wire logic [DAC_WIDTH-1:0] analogInZero,
   input  wire logic [DAC_WIDTH-1:0] analogInOne,
   input  wire logic [DAC_WIDTH-1:0] analogInTwo,
   input  wire logic [DAC_WIDTH-1:0] analogInThree,
   input  wire logic [3:0]           portLatch,
   input  wire logic [3:0]           portDriveEn,
   input  wire logic [3:0]           portPinIn,
   output logic      [3:0]           portPinOut,
   output logic      [3:0]           portPinOe,
   output logic      [3:0]           portPinSync,
   output logic      [DAC_WIDTH-1:0] dacValue,
   output logic                      compareResult
);
   localparam int CNT_W = $clog2(INSTR_CLKS + 1);
   localparam int AST_LAT = INSTR_CLKS;
   localparam int AST_DONE = INSTR_CLKS + 1;

   // Control and low register fields
   logic [1:0]     channelSel;
   logic           conversionStrobe;
   logic [3:0]     dacHigh;
   logic [3:0]     dacLow;
   logic [1:0]     next_channelSel;
   logic           next_conversionStrobe;
   logic [3:0]     next_dacHigh;
   logic [3:0]     next_dacLow;
   logic           next_compareResult;
   logic [7:0]     next_busRdData;
   // Compare sequencer
   swa_state_t     state;
   swa_state_t     next_state;
   logic [CNT_W-1:0] settleCnt;
   logic [CNT_W-1:0] next_settleCnt;
   // Pin side, comparator and bus decode
   logic [3:0]     next_portPinOut;
   logic [3:0]     next_portPinOe;
   logic [3:0]     analogMask;
   logic [DAC_WIDTH-1:0] next_dacValue;
   logic [DAC_WIDTH-1:0] lvlZero;
   logic [DAC_WIDTH-1:0] lvlOne;
   logic [DAC_WIDTH-1:0] lvlTwo;
   logic [DAC_WIDTH-1:0] lvlThree;
   logic           cmpHigh;
   logic           wrCtrl;
   logic           wrLow;
   logic           done;

   // Map a channel code to the port line it uses
   function automatic logic [3:0] chan_line(input logic [1:0] ch);
      case (ch)
         CH_SEL_IN3: chan_line = 4'h8;
         CH_SEL_IN0: chan_line = 4'h1;
         CH_SEL_IN1: chan_line = 4'h2;
         CH_SEL_IN2: chan_line = 4'h4;
         default:    chan_line = 4'h8;
      endcase
   endfunction

   // Analogue levels come from pins, so synchronise them
   swa_sync #(.WIDTH(4 * DAC_WIDTH)) uSyncLvl (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn ({analogInThree, analogInTwo, analogInOne, analogInZero}),
      .syncOut ({lvlThree, lvlTwo, lvlOne, lvlZero})
   );

   // Digital view of the shared port lines
   swa_sync #(.WIDTH(4)) uSyncPin (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn (portPinIn),
      .syncOut (portPinSync)
   );

   // Mux and comparator against the live DAC value
   swa_cmp #(.WIDTH(DAC_WIDTH)) uCmp (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .channelSel (channelSel),
      .levelZero  (lvlZero),
      .levelOne   (lvlOne),
      .levelTwo   (lvlTwo),
      .levelThree (lvlThree),
      .dacLevel   (dacValue),
      .cmpHigh    (cmpHigh)
   );

   // Address decode
   assign wrCtrl = busWr && (busAddr == ADDR_CTRL);
   assign wrLow  = busWr && (busAddr == ADDR_LOW);
   assign done   = (state == SWA_CMP) && (settleCnt == '0);

   // Register file next values
   always_comb begin
      next_channelSel = channelSel;
      next_dacHigh    = dacHigh;
      next_dacLow     = dacLow;
      if (wrCtrl) begin
         // R1 channel write
         next_channelSel = busWrData[CTRL_CH_HI_BIT:CTRL_CH_LO_BIT];
         next_dacHigh    = busWrData[CTRL_DAC_MSB:0];
      end
      if (wrLow) begin
         // R9 low nibble
         next_dacLow = busWrData[LOW_DAC_MSB:0];
      end
      // R3 DAC concatenation
      next_dacValue = DAC_WIDTH'({next_dacHigh, next_dacLow});
   end

   // Read data, valid only in the cycle after the strobe
   always_comb begin
      next_busRdData = 8'h00;
      if (busRd) begin
         case (busAddr)
            // R8 control readback
            ADDR_CTRL: next_busRdData = {compareResult, channelSel,
                                         conversionStrobe, dacHigh};
            // R9 upper bits zero
            ADDR_LOW:  next_busRdData = {4'h0, dacLow};
            default:   next_busRdData = 8'h00;
         endcase
      end
   end

   // Single compare sequencer; software does the approximation
   // R7 single compare only
   always_comb begin
      next_state            = state;
      next_settleCnt        = settleCnt;
      next_conversionStrobe = conversionStrobe;
      next_compareResult    = compareResult;
      case (state)
         SWA_IDLE: begin
         end
         SWA_CMP: begin
            if (settleCnt != '0) begin
               next_settleCnt = settleCnt - 1'b1;
            end else begin
               // R4 result capture
               next_compareResult    = cmpHigh;
               next_conversionStrobe = 1'b0;
               next_state            = SWA_IDLE;
            end
         end
         default: begin
            next_state = SWA_IDLE;
         end
      endcase
      // R5 strobe starts compare; a new write wins over completion for strobe and state, not for the result capture
      if (wrCtrl) begin
         next_conversionStrobe = busWrData[CTRL_STROBE_BIT];
         if (busWrData[CTRL_STROBE_BIT]) begin
            next_state     = SWA_CMP;
            next_settleCnt = CNT_W'(INSTR_CLKS - 1);
         end else begin
            next_state = SWA_IDLE;
         end
      end
   end

   // Port line sharing
   always_comb begin
      // R2 selected line released for analogue
      analogMask      = conversionStrobe ? chan_line(channelSel) : 4'h0;
      next_portPinOut = portLatch & ~analogMask;
      next_portPinOe  = portDriveEn & ~analogMask;
   end

   // State registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // R8 reset values
         channelSel       <= CTRL_RESET[CTRL_CH_HI_BIT:CTRL_CH_LO_BIT];
         conversionStrobe <= CTRL_RESET[CTRL_STROBE_BIT];
         dacHigh          <= CTRL_RESET[CTRL_DAC_MSB:0];
         compareResult    <= CTRL_RESET[CTRL_RESULT_BIT];
         dacLow           <= LOW_RESET[LOW_DAC_MSB:0];
         dacValue         <= '0;
         busRdData        <= 8'h00;
         state            <= SWA_IDLE;
         settleCnt        <= '0;
         portPinOut       <= 4'h0;
         portPinOe        <= 4'h0;
      end else begin
         channelSel       <= next_channelSel;
         conversionStrobe <= next_conversionStrobe;
         dacHigh          <= next_dacHigh;
         compareResult    <= next_compareResult;
         dacLow           <= next_dacLow;
         dacValue         <= next_dacValue;
         busRdData        <= next_busRdData;
         state            <= next_state;
         settleCnt        <= next_settleCnt;
         portPinOut       <= next_portPinOut;
         portPinOe        <= next_portPinOe;
      end
   end

   // Cycles the strobe has been high since its last start
   logic [15:0] astHighCnt;
   logic [15:0] next_astHighCnt;
   always_comb begin
      next_astHighCnt = astHighCnt + 16'h0001;
      if (wrCtrl || !conversionStrobe) begin
         next_astHighCnt = 16'h0000;
      end
   end

   // Strobe age register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         astHighCnt <= 16'h0000;
      end else begin
         astHighCnt <= next_astHighCnt;
      end
   end

   sequence seqStart;
      wrCtrl && busWrData[CTRL_STROBE_BIT];
   endsequence

   sequence seqSettle;
      (conversionStrobe && !wrCtrl) [*2];
   endsequence

   AST_STROBE_BOUND: assert property (@(posedge clk_sys) // R5
      disable iff (rst) astHighCnt <= 16'(AST_LAT))
      else $error("strobe held longer than one instruction cycle");

   AST_START_SEEN: assert property (@(posedge clk_sys) disable iff (rst) // R5
      seqStart |=> conversionStrobe && state == SWA_CMP)
      else $error("strobe write did not start a compare");

   AST_RESULT_CAPTURE: assert property (@(posedge clk_sys) // R4
      disable iff (rst) done && !wrCtrl |=>
      compareResult == $past(cmpHigh) && !conversionStrobe)
      else $error("result not taken from comparator");

   AST_DAC_VALUE: assert property (@(posedge clk_sys) disable iff (rst) // R3
      dacValue == DAC_WIDTH'({dacHigh, dacLow}))
      else $error("DAC value does not match register nibbles");

   AST_CTRL_RESET: assert property (@(posedge clk_sys) rst |=> // R8
      channelSel == 2'h0 && !conversionStrobe && dacHigh == 4'h0 &&
      !compareResult && dacLow == 4'h0)
      else $error("registers not cleared by reset");

   AST_CTRL_READ: assert property (@(posedge clk_sys) disable iff (rst) // R8
      busRd && busAddr == ADDR_CTRL |=> busRdData ==
      $past({compareResult, channelSel, conversionStrobe, dacHigh}))
      else $error("control readback wrong");

   AST_LOW_READ: assert property (@(posedge clk_sys) disable iff (rst) // R9
      busRd && busAddr == ADDR_LOW |=> busRdData == {4'h0, $past(dacLow)})
      else $error("low register readback wrong");

   AST_CH_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // R1
      busWr && busAddr == ADDR_CTRL |=>
      channelSel == $past(busWrData[CTRL_CH_HI_BIT:CTRL_CH_LO_BIT]))
      else $error("channel field not written");

   AST_PIN_RELEASE: assert property (@(posedge clk_sys) disable iff (rst) // R2
      seqStart ##1 seqSettle |->
      (portPinOe & chan_line(channelSel)) == 4'h0)
      else $error("selected analogue line still driven");

   AST_RESULT_TIME: assert property (@(posedge clk_sys) // R5
      disable iff (rst) seqStart |-> ##[1:AST_DONE]
      (!conversionStrobe || wrCtrl))
      else $error("compare outlasted one instruction cycle");

   AST_ABORT_KEEP: assert property (@(posedge clk_sys) disable iff (rst) // R4
      wrCtrl && !busWrData[CTRL_STROBE_BIT] && !done |=>
      !conversionStrobe && compareResult == $past(compareResult))
      else $error("aborted compare changed the result");

   AST_LOW_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // R9
      wrLow |=> dacLow == $past(busWrData[LOW_DAC_MSB:0]))
      else $error("low DAC nibble not written");

   AST_HIGH_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // R3
      wrCtrl |=> dacHigh == $past(busWrData[CTRL_DAC_MSB:0]))
      else $error("high DAC nibble not written");
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import swa_pkg::*;
();
   localparam int INSTR = 6;

   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] busAddr = 8'h00;
   logic [7:0] busWrData = 8'h00;
   logic       busWr = 1'b0;
   logic       busRd = 1'b0;
   logic [7:0] busRdData;
   logic [7:0] analogIn [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [3:0] portLatch = 4'h0;
   logic [3:0] portDriveEn = 4'h0;
   logic [3:0] portPinIn = 4'h0;
   logic [3:0] portPinOut;
   logic [3:0] portPinOe;
   logic [3:0] portPinSync;
   logic [7:0] dacValue;
   logic       compareResult;
   logic [7:0] expQ [$];
   logic       rdSeen = 1'b0;
   logic       lastRes = 1'b0;
   int         fails = 0;
   int         checked = 0;

   swa_top #(.DAC_WIDTH(8), .INSTR_CLKS(INSTR)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .busAddr(busAddr),
      .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
      .busRdData(busRdData), .analogInZero(analogIn[0]),
      .analogInOne(analogIn[1]), .analogInTwo(analogIn[2]),
      .analogInThree(analogIn[3]), .portLatch(portLatch),
      .portDriveEn(portDriveEn), .portPinIn(portPinIn),
      .portPinOut(portPinOut), .portPinOe(portPinOe),
      .portPinSync(portPinSync), .dacValue(dacValue),
      .compareResult(compareResult));

   // Clock, 100 ns period
   always #50 clk_sys = ~clk_sys;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Bus cycles, each taken at the edge that ends the task
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      busAddr <= a;
      busWrData <= d;
      busWr <= 1'b1;
      busRd <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      busAddr <= a;
      busRd <= 1'b1;
      busWr <= 1'b0;
      expQ.push_back(exp);
      @(posedge clk_sys);
   endtask

   task automatic idle(input int n);
      busWr <= 1'b0;
      busRd <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask

   // Read data checked in the cycle after the read strobe
   always @(posedge clk_sys) begin
      if (rdSeen) begin
         if (expQ.size() == 0)
            chk(busRdData, 8'hXX);
         else
            chk(busRdData, expQ.pop_front());
      end
      rdSeen <= busRd & ~rst;
   end

   // One software conversion step, optionally aborted
   task automatic conv(input logic [1:0] ch, input logic [3:0] hi,
                       input logic [3:0] lo, input int mode);
      logic [7:0] dac;
      logic [7:0] sel;
      logic [7:0] r;
      logic [3:0] mask;
      logic       res;
      int         line;
      dac = {hi, lo};
      r = 8'($urandom);
      sel = (mode == 1) ? dac : (mode == 2) ? dac + 8'h01 : r;
      line = (ch == 2'h0) ? 3 : int'(ch) - 1;
      mask = 4'h1 << line;
      for (int i = 0; i < 4; i++)
         analogIn[i] <= (i == line) ? sel : 8'($urandom);
      portLatch <= r[3:0];
      portDriveEn <= r[7:4];
      res = (sel > dac);
      // upper bits set ahead of strobe
      wr(ADDR_LOW, {r[7:4], lo});
      wr(ADDR_CTRL, {1'b0, ch, 1'b0, hi});
      idle(INSTR);
      wr(ADDR_CTRL, {1'b1, ch, 1'b1, hi});
      rd(ADDR_CTRL, {lastRes, ch, 1'b1, hi});
      rd(ADDR_LOW, {4'h0, lo});
      idle(1);
      @(negedge clk_sys);
      chk({4'h0, portPinOe}, {4'h0, r[7:4] & ~mask});
      chk({7'h0, |(portPinOut & mask)}, 8'h00);
      chk({4'h0, portPinOut}, {4'h0, r[3:0] & ~mask});
      chk(dacValue, dac);
      @(posedge clk_sys);
      if (mode == 3) begin
         wr(ADDR_CTRL, {1'b0, ch, 1'b0, hi});
         res = lastRes;
      end
      // Four edges since the strobe write, five after an abort; result due at the bound
      idle(INSTR - 4);
      @(negedge clk_sys);
      chk({7'h0, compareResult}, {7'h0, res});
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({4'h0, portPinOe}, {4'h0, r[7:4]});
      chk({4'h0, portPinOut}, {4'h0, r[3:0]});
      @(posedge clk_sys);
      rd(ADDR_CTRL, {res, ch, 1'b0, hi});
      idle(1);
      lastRes = res;
   endtask

   initial begin
      logic [7:0] r;
      void'($urandom(32'hF8DD3882));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      idle(3);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_LOW, LOW_RESET);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      rd(ADDR_CTRL, 8'h00);
      idle(1);
      r = 8'($urandom);
      portPinIn <= r[3:0];
      idle(4);
      @(negedge clk_sys);
      chk({4'h0, portPinSync}, {4'h0, r[3:0]});
      @(posedge clk_sys);
      for (int k = 0; k < 16; k++) begin
         r = 8'($urandom);
         conv(2'(k), r[7:4], r[3:0], k / 4);
      end
      conv(2'h3, 4'hF, 4'hF, 2);
      conv(2'h0, 4'h0, 4'h0, 1);
      wr(ADDR_LOW, 8'h0F);
      wr(ADDR_CTRL, 8'h7F);
      rst <= 1'b1;
      idle(3);
      rst <= 1'b0;
      idle(3);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_LOW, LOW_RESET);
      idle(1);
      @(negedge clk_sys);
      chk(dacValue, 8'h00);
      chk({7'h0, compareResult}, 8'h00);
      @(posedge clk_sys);
      give_verdict();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
